// [core/rrx_pkg.sv]
// constants and types for the return and rotate execution block
// ----------------------------------------------------------------
// Overview of operation
// - return_with_literal loads the 8-bit literal into W, no status flag changes.
// - return_with_literal loads PC from stack_top and pops that stack entry.
// - return_with_literal is one word and takes two instruction cycles.
// - plain return pops the stack and loads PC from stack_top, flags untouched.
// - plain return is one word, two cycles, and flushes the fetch pipeline.
// - rotate shifts f left, old carry into bit 0, bit 7 into carry.
// - rotate destination bit 0 writes W, bit 1 writes file register 0..127.
// ----------------------------------------------------------------
`default_nettype none

package rrx_pkg;

    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;

    // instruction word encodings
    localparam logic [3:0] RET_LIT_PFX = 4'hd;
    localparam int RET_LIT_PFX_HI = 13;
    localparam int RET_LIT_PFX_LO = 10;
    localparam logic [13:0] RET_WORD = 14'h0008;
    localparam logic [5:0] ROT_PFX = 6'h0d;
    localparam int ROT_PFX_HI = 13;
    localparam int ROT_PFX_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int LIT_HI = 7;
    localparam int FADDR_HI = 6;

    // execution cycle counts
    localparam int RET_CYCLES = 2;
    localparam int ROT_CYCLES = 1;

    localparam logic [7:0] W_RST = 8'h00;
    localparam logic CARRY_RST = 1'b0;

    typedef enum logic [1:0] {
        RRX_OP_NONE,
        RRX_OP_RET_LIT,
        RRX_OP_RET,
        RRX_OP_ROT
    } rrx_op_e;

    typedef enum {
        RRX_ST_EXEC,
        RRX_ST_FLUSH
    } rrx_state_e;

endpackage

`default_nettype wire

// [core/rrx_exec.sv]
// executes return-with-literal, return and rotate-left-through-carry
`default_nettype none

module rrx_exec #(
    parameter int PC_W = 13
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [rrx_pkg::INSTR_W-1:0] instr_word,
    output logic instr_ready,
    input wire logic [PC_W-1:0] stack_top,
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_addr,
    output logic pipe_flush,
    output logic [rrx_pkg::FADDR_W-1:0] file_rd_addr,
    input wire logic [rrx_pkg::DATA_W-1:0] file_rd_data,
    output logic file_wr_en,
    output logic [rrx_pkg::FADDR_W-1:0] file_wr_addr,
    output logic [rrx_pkg::DATA_W-1:0] file_wr_data,
    output logic [rrx_pkg::DATA_W-1:0] w_out,
    output logic carry_out,
    output logic instr_done
);
    import rrx_pkg::*;

    if (PC_W < 1 || PC_W > 16) begin : g_bad_pc_w
        $error("PC_W must be 1 to 16");
    end
    // sequencer only knows a two-slot return and a one-slot rotate
    if (RET_CYCLES != 2 || ROT_CYCLES != 1) begin : g_bad_cycles
        $error("cycle counts not served by the sequencer");
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic rrx_op_e decode_op(input logic [INSTR_W-1:0] word);
        if (word[RET_LIT_PFX_HI:RET_LIT_PFX_LO] == RET_LIT_PFX) begin
            return RRX_OP_RET_LIT;
        end else if (word == RET_WORD) begin
            return RRX_OP_RET;
        end else if (word[ROT_PFX_HI:ROT_PFX_LO] == ROT_PFX) begin
            return RRX_OP_ROT;
        end
        return RRX_OP_NONE;
    endfunction

    rrx_state_e state_reg;
    rrx_state_e state_next;
    logic [DATA_W-1:0] w_reg;
    logic carry_reg;
    logic stack_pop_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_addr_reg;
    logic file_wr_en_reg;
    logic [FADDR_W-1:0] file_wr_addr_reg;
    logic [DATA_W-1:0] file_wr_data_reg;
    logic done_reg;
    rrx_op_e op;
    logic take;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;

    assign op = decode_op(instr_word);
    // second return cycle refuses new work while fetch refills
    assign instr_ready = (state_reg == RRX_ST_EXEC);
    assign take = instr_valid && instr_ready;
    assign file_rd_addr = instr_word[FADDR_HI:0];
    assign {rot_carry, rot_result} = {file_rd_data, carry_reg};

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RRX_ST_EXEC: begin
                if (take && (op == RRX_OP_RET_LIT || op == RRX_OP_RET)) begin
                    state_next = RRX_ST_FLUSH;
                end
            end
            RRX_ST_FLUSH: begin
                state_next = RRX_ST_EXEC;
            end
            default: begin
                state_next = RRX_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= RRX_ST_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // working accumulator and carry
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_reg <= W_RST;
        end else if (take && op == RRX_OP_RET_LIT) begin
            w_reg <= instr_word[LIT_HI:0];
        end else if (take && op == RRX_OP_ROT && !instr_word[DEST_BIT]) begin
            w_reg <= rot_result;
        end
    end

    // returns never touch carry; only the rotate does
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carry_reg <= CARRY_RST;
        end else if (take && op == RRX_OP_ROT) begin
            carry_reg <= rot_carry;
        end
    end

    // ----------------------------------------------------------------
    // stack and program counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_pop_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            pc_addr_reg <= '0;
        end else begin
            stack_pop_reg <= take && (op == RRX_OP_RET_LIT || op == RRX_OP_RET);
            pc_load_reg <= take && (op == RRX_OP_RET_LIT || op == RRX_OP_RET);
            if (take && (op == RRX_OP_RET_LIT || op == RRX_OP_RET)) begin
                pc_addr_reg <= stack_top;
            end
        end
    end

    // ----------------------------------------------------------------
    // file register write-back and completion
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            file_wr_en_reg <= 1'b0;
            file_wr_addr_reg <= '0;
            file_wr_data_reg <= '0;
        end else begin
            file_wr_en_reg <= take && op == RRX_OP_ROT && instr_word[DEST_BIT];
            if (take && op == RRX_OP_ROT) begin
                file_wr_addr_reg <= instr_word[FADDR_HI:0];
                file_wr_data_reg <= rot_result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (take && op == RRX_OP_ROT) || state_reg == RRX_ST_FLUSH;
        end
    end

    assign stack_pop = stack_pop_reg;
    assign pc_load = pc_load_reg;
    assign pc_load_addr = pc_addr_reg;
    assign pipe_flush = (state_reg == RRX_ST_FLUSH);
    assign file_wr_en = file_wr_en_reg;
    assign file_wr_addr = file_wr_addr_reg;
    assign file_wr_data = file_wr_data_reg;
    assign w_out = w_reg;
    assign carry_out = carry_reg;
    assign instr_done = done_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    lit_to_w_a: assert property (take && op == RRX_OP_RET_LIT |=>
        w_out == $past(instr_word[LIT_HI:0]) && carry_out == $past(carry_out))
        else $error("literal not loaded into W or carry disturbed");
    ret_lit_pc_a: assert property (take && op == RRX_OP_RET_LIT |=>
        pc_load && stack_pop && pc_load_addr == $past(stack_top))
        else $error("return with literal did not load PC from stack top");
    ret_lit_two_a: assert property (take && op == RRX_OP_RET_LIT |=>
        !instr_ready ##1 instr_done && instr_ready)
        else $error("return with literal not two cycles");
    ret_pop_a: assert property (take && op == RRX_OP_RET |=>
        stack_pop && pc_load_addr == $past(stack_top) && $stable(carry_out)
        && $stable(w_out))
        else $error("return did not pop cleanly");
    ret_flush_a: assert property (take && op == RRX_OP_RET |=>
        pipe_flush ##1 !pipe_flush && instr_done)
        else $error("return flush not one cycle in second slot");
    rot_carry_a: assert property (take && op == RRX_OP_ROT |=>
        carry_out == $past(file_rd_data[DATA_W-1]))
        else $error("rotate carry wrong");
    rot_dest_w_a: assert property (take && op == RRX_OP_ROT && !instr_word[DEST_BIT] |=>
        w_out == {$past(file_rd_data[DATA_W-2:0]), $past(carry_out)} && !file_wr_en)
        else $error("rotate to W wrong");
    rot_dest_f_a: assert property (take && op == RRX_OP_ROT && instr_word[DEST_BIT] |=>
        file_wr_en && file_wr_addr == $past(instr_word[FADDR_HI:0])
        && file_wr_data == {$past(file_rd_data[DATA_W-2:0]), $past(carry_out)}
        && $stable(w_out))
        else $error("rotate to file wrong");
    rot_single_a: assert property (take && op == RRX_OP_ROT |=>
        instr_done && instr_ready && !pipe_flush)
        else $error("rotate not single cycle");
    pc_hold_a: assert property (!(take && (op == RRX_OP_RET_LIT || op == RRX_OP_RET)) |=>
        !pc_load && !stack_pop && $stable(pc_load_addr))
        else $error("program counter load without a return");

    ret_lit_c: cover property (take && op == RRX_OP_RET_LIT ##2 take && op == RRX_OP_ROT);
    ret_c: cover property (take && op == RRX_OP_RET ##1 instr_valid && !instr_ready);
    rot_f_c: cover property (take && op == RRX_OP_ROT && instr_word[DEST_BIT]);
    rot_w_c: cover property (take && op == RRX_OP_ROT && !instr_word[DEST_BIT]);
    rot_back_c: cover property (take && op == RRX_OP_ROT ##1 take && op == RRX_OP_ROT);

endmodule

`default_nettype wire

// [sim/tb_return_and_rotate_exec.sv]
// self-checking bench for the return and rotate execution block
`default_nettype none

module tb_return_and_rotate_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import rrx_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr_word = 14'h0000;
    logic [12:0] stack_top = 13'h0000;
    logic [DATA_W-1:0] file_rd_data = 8'h00;
    logic instr_ready, stack_pop, pc_load, pipe_flush, file_wr_en, carry_out, instr_done;
    logic [12:0] pc_load_addr;
    logic [FADDR_W-1:0] file_rd_addr, file_wr_addr, fa;
    logic [DATA_W-1:0] file_wr_data, w_out, mw, res;
    logic [12:0] pc_exp;
    logic [31:0] seed = 32'h0000_003b;
    logic mc, flush, tk, rot, ret, d;
    int n_fail = 0;
    int tests_run = 0;
    int i, k;

    rrx_exec #(.PC_W(13)) u_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .stack_top(stack_top),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .pipe_flush(pipe_flush), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
        .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .w_out(w_out), .carry_out(carry_out), .instr_done(instr_done));

    initial begin
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // {new carry, result}: old carry enters at the bottom
    function automatic logic [8:0] rot_fn(input logic [7:0] v, input logic c);
        return {v, c};
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task final_report();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // picks at i 0, 1, 3 and 4 are fixed corners (i 2 is a return's refused cycle), then random mix incl. idle and junk words
    task drive();
        logic [31:0] r;
        r = xs();
        k = (i < 5) ? i + 5 : int'(r[31:29]) % 5;
        instr_valid <= (k != 3);
        stack_top <= r[12:0];
        file_rd_data <= (i == 0) ? 8'he6 : r[20:13];
        case (k)
            0: instr_word <= {RET_LIT_PFX, r[22:21], r[7:0]};
            1: instr_word <= RET_WORD;
            2: instr_word <= {ROT_PFX, r[21], r[28:22]};
            4: instr_word <= 14'h0000;
            5: instr_word <= {ROT_PFX, 1'b0, 7'h7f};
            6: instr_word <= {RET_LIT_PFX, 2'b00, 8'hff};
            7: instr_word <= {RET_LIT_PFX, 2'b11, 8'h00};
            8: instr_word <= {ROT_PFX, 1'b1, 7'h00};
            9: instr_word <= RET_WORD;
            default: instr_word <= instr_word;
        endcase
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("w_out", 16'(W_RST), 16'(w_out));
        chk("instr_ready", 16'h0001, 16'(instr_ready));
        mw = W_RST;
        mc = CARRY_RST;
        flush = 1'b0;
        pc_exp = 13'h0000;
        for (i = 0; i < 400; i++) begin
            // mid-run reset, one edge after the last driven word
            if (i == 250) begin
                @(posedge clk);
                sys_rst <= 1'b1;
                instr_valid <= 1'b0;
                @(posedge clk);
                sys_rst <= 1'b0;
                mw = W_RST;
                mc = CARRY_RST;
                flush = 1'b0;
                pc_exp = '0;
            end
            @(posedge clk);
            tk = instr_valid && !flush;
            rot = tk && instr_word[13:8] == ROT_PFX;
            ret = tk && (instr_word[13:10] == RET_LIT_PFX || instr_word == RET_WORD);
            d = instr_word[DEST_BIT];
            fa = instr_word[6:0];
            {mc, res} = rot ? rot_fn(file_rd_data, mc) : {mc, res};
            if (rot && !d) mw = res;
            if (tk && instr_word[13:10] == RET_LIT_PFX) mw = instr_word[7:0];
            if (ret) pc_exp = stack_top;
            // a taken return leaves its word on the bus through the refused cycle
            if (!ret) drive();
            #1;
            chk("instr_ready", 16'(!ret), 16'(instr_ready));
            chk("pipe_flush", 16'(ret), 16'(pipe_flush));
            chk("stack_pop", 16'(ret), 16'(stack_pop));
            chk("pc_load", 16'(ret), 16'(pc_load));
            chk("pc_load_addr", 16'(pc_exp), 16'(pc_load_addr));
            chk("instr_done", 16'(flush || rot), 16'(instr_done));
            chk("file_wr_en", 16'(rot && d), 16'(file_wr_en));
            if (rot && d) chk("file_wr", 16'({fa, res}), 16'({file_wr_addr, file_wr_data}));
            if (instr_valid) chk("file_rd_addr", 16'(instr_word[6:0]), 16'(file_rd_addr));
            chk("w_out", 16'(mw), 16'(w_out));
            chk("carry_out", 16'(mc), 16'(carry_out));
            flush = ret;
        end
        final_report();
    end

    // run needs about 410 cycles; cut a hang well beyond that
    initial begin
        #40000;
        n_fail++;
        final_report();
    end
endmodule

`default_nettype wire
